// >>> design/dtc_pkg.sv
// Overview of operation
// - Each timer is a 16-bit count built from a high and a low byte register.
// - Each timer runs one of four modes chosen by a two-bit mode field.
// - 13-bit mode counts high byte plus five low bits of the low byte.
// - Overflow sets the timer flag and requests an interrupt when enabled.
// - Counter select 1 counts pin falling edges, 0 counts the clock.
// - Count only with run set and gate clear or gate input high; in split mode timer 1 ignores both and the high half ignores the gate.
// - Starting a timer keeps the count; it resumes from the held value.
// - Each timer picks the undivided or divided-by-twelve clock.
// - In timer use with compare enabled, overflow toggles the timer pin.
// - Compare enable forces the timer pin to drive as an output.
// - 16-bit mode is like 13-bit mode but uses all sixteen bits.
// - Auto-reload counts in the low byte and reloads it from the high byte.
// - Auto-reload leaves the high byte reload value unchanged.
// - Overflow interrupt is forwarded only while its enable bit is set.
// - Mode codes: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split.
// - Split mode: timer 0 high half clocks, uses timer 1 run and flag.
// - Prescale bit 0 selects divide by twelve, 1 the undivided clock.
// - Software clears flags; software setting a flag raises the interrupt.
package dtc_pkg;
  // ==========================================
  // Register map
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_LOW_A = 3'h2;
  localparam logic [2:0] ADDR_LOW_B = 3'h3;
  localparam logic [2:0] ADDR_HIGH_A = 3'h4;
  localparam logic [2:0] ADDR_HIGH_B = 3'h5;
  localparam logic [2:0] ADDR_CLOCK = 3'h6;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h7;
  // ==========================================
  // Control register fields
  localparam int BIT_FLAG_B = 7;
  localparam int BIT_RUN_B = 6;
  localparam int BIT_FLAG_A = 5;
  localparam int BIT_RUN_A = 4;
  // ==========================================
  // Mode register fields, per timer nibble
  localparam int BIT_GATE = 3;
  localparam int BIT_CSEL = 2;
  localparam int MODE_LSB = 0;
  // ==========================================
  // Clock register fields
  localparam int BIT_PRESCALE_A = 2;
  localparam int BIT_TOGGLE_A = 0;
  // ==========================================
  // Interrupt enable fields
  localparam int BIT_IRQ_EN_A = 1;
  localparam int BIT_IRQ_EN_B = 3;
  // ==========================================
  // Reset values and counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] PRESCALE_LAST = 4'hB;
  // ==========================================
  // Modes
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'h0,
    DTC_MODE_16 = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT = 2'h3
  } dtc_mode_t;
endpackage

// >>> design/dtc_sync.sv
`timescale 1ns/1ps
module dtc_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  logic stage_reg;

  // ==========================================
  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule

// >>> design/dtc_timer.sv
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module dtc_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Count pins, one per timer
  input wire logic [1:0] count_pin_in,
  output logic [1:0] count_pin_out,
  output logic [1:0] count_pin_oe,
  // External gate inputs
  input wire logic [1:0] external_gate_input,
  // Interrupt requests
  output logic [1:0] timer_irq
);
  logic [7:0] timer_control_register_reg;
  logic [7:0] timer_mode_register_reg;
  logic [3:0] timer_clock_register_reg;
  logic [7:0] interrupt_enable_register_reg;
  logic [7:0] count_low_byte_reg [2];
  logic [7:0] count_high_byte_reg [2];
  logic [3:0] prescale_reg;
  logic prescale_tick;
  logic [1:0] pin_sync;
  logic [1:0] gate_sync;
  logic [1:0] pin_prev_reg;
  logic [1:0] pin_fall;
  logic [1:0] toggle_reg;
  logic [1:0] run_bit;
  logic [1:0] overflow_flag;
  logic [1:0] gate_select;
  logic [1:0] counter_select;
  logic [1:0] prescale_select;
  logic [1:0] compare_toggle_enable;
  logic [1:0] irq_enable;
  logic [1:0] tick;
  logic [1:0] low_ovf;
  logic [1:0] word_ovf;
  logic [1:0] ovf_event;
  logic high_split_tick;
  logic high_split_ovf;
  logic split_active;
  logic [7:0] low_next [2];
  logic [7:0] high_next [2];
  logic [7:0] rdata_next;
  logic [3:0] mode_nib [2];
  dtc_pkg::dtc_mode_t mode [2];

  // ==========================================
  // Field decode helpers
  function automatic logic [3:0] nib(input logic [7:0] r, input int t);
    nib = (t == 0) ? r[3:0] : r[7:4];
  endfunction

  function automatic logic clk_enable(input logic psel, input logic ptick);
    clk_enable = psel | ptick;
  endfunction

  // ==========================================
  // Input synchronisers
  for (genvar t = 0; t < 2; t++) begin : g_sync
    dtc_sync u_pin (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(count_pin_in[t]),
      .sync_out(pin_sync[t])
    );
    dtc_sync u_gate (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(external_gate_input[t]),
      .sync_out(gate_sync[t])
    );
  end

  // Falling edge from successive synchronised samples
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_prev_reg <= 2'h0;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end
  assign pin_fall = pin_prev_reg & ~pin_sync;

  // ==========================================
  // Shared divide-by-twelve prescaler
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prescale_reg <= 4'h0;
    end else if (prescale_reg == dtc_pkg::PRESCALE_LAST) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end
  assign prescale_tick = (prescale_reg == dtc_pkg::PRESCALE_LAST);

  // ==========================================
  // Field extraction
  assign split_active = (mode[0] == dtc_pkg::DTC_MODE_SPLIT);
  for (genvar t = 0; t < 2; t++) begin : g_fields
    assign mode_nib[t] = nib(timer_mode_register_reg, t);
    assign mode[t] = dtc_pkg::dtc_mode_t'(mode_nib[t][dtc_pkg::MODE_LSB +: 2]);
    assign gate_select[t] = mode_nib[t][dtc_pkg::BIT_GATE];
    assign counter_select[t] = mode_nib[t][dtc_pkg::BIT_CSEL];
    assign prescale_select[t] = timer_clock_register_reg[dtc_pkg::BIT_PRESCALE_A + t];
    assign compare_toggle_enable[t] = timer_clock_register_reg[dtc_pkg::BIT_TOGGLE_A + t];
    assign irq_enable[t] = interrupt_enable_register_reg[dtc_pkg::BIT_IRQ_EN_A + 2 * t];
  end
  assign run_bit[0] = timer_control_register_reg[dtc_pkg::BIT_RUN_A];
  assign run_bit[1] = timer_control_register_reg[dtc_pkg::BIT_RUN_B];
  assign overflow_flag[0] = timer_control_register_reg[dtc_pkg::BIT_FLAG_A];
  assign overflow_flag[1] = timer_control_register_reg[dtc_pkg::BIT_FLAG_B];

  // ==========================================
  // Count enables
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      // Timer 1 loses its run bit, gate and pin while timer 0 is split
      if (t == 1 && split_active) begin
        tick[t] = (mode[1] != dtc_pkg::DTC_MODE_SPLIT)
                  & clk_enable(prescale_select[1], prescale_tick);
      end else begin
        tick[t] = run_bit[t] & (~gate_select[t] | gate_sync[t])
                  & (counter_select[t] ? pin_fall[t]
                     : clk_enable(prescale_select[t], prescale_tick));
      end
    end
  end
  assign high_split_tick = split_active & run_bit[1]
                           & clk_enable(prescale_select[0], prescale_tick);

  // ==========================================
  // Count arithmetic
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      low_next[t] = count_low_byte_reg[t];
      high_next[t] = count_high_byte_reg[t];
      low_ovf[t] = 1'b0;
      word_ovf[t] = 1'b0;
      if (tick[t]) begin
        case (mode[t])
          dtc_pkg::DTC_MODE_13: begin
            // Upper three low bits are left as they are
            low_next[t] = {count_low_byte_reg[t][7:5], count_low_byte_reg[t][4:0] + 5'h01};
            if (count_low_byte_reg[t][4:0] == 5'h1F) begin
              high_next[t] = count_high_byte_reg[t] + 8'h01;
              word_ovf[t] = (count_high_byte_reg[t] == 8'hFF);
            end
          end
          dtc_pkg::DTC_MODE_16: begin
            low_next[t] = count_low_byte_reg[t] + 8'h01;
            if (count_low_byte_reg[t] == 8'hFF) begin
              high_next[t] = count_high_byte_reg[t] + 8'h01;
              word_ovf[t] = (count_high_byte_reg[t] == 8'hFF);
            end
          end
          dtc_pkg::DTC_MODE_RELOAD: begin
            if (count_low_byte_reg[t] == 8'hFF) begin
              low_next[t] = count_high_byte_reg[t];
              low_ovf[t] = 1'b1;
            end else begin
              low_next[t] = count_low_byte_reg[t] + 8'h01;
            end
          end
          default: begin
            // Split: low byte of timer 0 is an 8-bit counter; timer 1 holds
            low_next[t] = (t == 0) ? count_low_byte_reg[t] + 8'h01 : count_low_byte_reg[t];
            low_ovf[t] = (t == 0) && (count_low_byte_reg[t] == 8'hFF);
          end
        endcase
      end
    end
    // Split high half of timer 0
    high_split_ovf = high_split_tick & (count_high_byte_reg[0] == 8'hFF);
    if (high_split_tick) begin
      high_next[0] = count_high_byte_reg[0] + 8'h01;
    end
  end

  // Timer 1 cannot raise its flag while timer 0 is split
  assign ovf_event[0] = low_ovf[0] | word_ovf[0];
  assign ovf_event[1] = split_active ? high_split_ovf
                        : (low_ovf[1] | word_ovf[1]);

  // ==========================================
  // Count registers; a software write wins over counting
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int t = 0; t < 2; t++) begin
        count_low_byte_reg[t] <= dtc_pkg::RESET_BYTE;
        count_high_byte_reg[t] <= dtc_pkg::RESET_BYTE;
      end
    end else begin
      for (int t = 0; t < 2; t++) begin
        // Held value survives a stop and restart
        if (reg_wr && reg_addr == dtc_pkg::ADDR_LOW_A + 3'(t)) begin
          count_low_byte_reg[t] <= reg_wdata;
        end else begin
          count_low_byte_reg[t] <= low_next[t];
        end
        if (reg_wr && reg_addr == dtc_pkg::ADDR_HIGH_A + 3'(t)) begin
          count_high_byte_reg[t] <= reg_wdata;
        end else begin
          count_high_byte_reg[t] <= high_next[t];
        end
      end
    end
  end

  // ==========================================
  // Control register; hardware flag set wins over software clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_control_register_reg <= dtc_pkg::RESET_BYTE;
    end else begin
      if (reg_wr && reg_addr == dtc_pkg::ADDR_CONTROL) begin
        timer_control_register_reg <= reg_wdata;
      end
      if (ovf_event[0]) begin
        timer_control_register_reg[dtc_pkg::BIT_FLAG_A] <= 1'b1;
      end
      if (ovf_event[1]) begin
        timer_control_register_reg[dtc_pkg::BIT_FLAG_B] <= 1'b1;
      end
    end
  end

  // ==========================================
  // Mode, clock and interrupt enable registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_mode_register_reg <= dtc_pkg::RESET_BYTE;
      timer_clock_register_reg <= 4'h0;
      interrupt_enable_register_reg <= dtc_pkg::RESET_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        dtc_pkg::ADDR_MODE: timer_mode_register_reg <= reg_wdata;
        dtc_pkg::ADDR_CLOCK: timer_clock_register_reg <= reg_wdata[3:0];
        dtc_pkg::ADDR_IRQ_EN: interrupt_enable_register_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Compare toggle pins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      toggle_reg <= 2'h0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (compare_toggle_enable[t] && !counter_select[t] && ovf_event[t]) begin
          toggle_reg[t] <= ~toggle_reg[t];
        end
      end
    end
  end
  assign count_pin_out = toggle_reg;
  assign count_pin_oe = compare_toggle_enable;

  // Interrupt request follows the flag, so a software set behaves like overflow
  assign timer_irq = overflow_flag & irq_enable;

  // ==========================================
  // Read port, data one cycle after the strobe
  always_comb begin
    case (reg_addr)
      dtc_pkg::ADDR_CONTROL: rdata_next = timer_control_register_reg;
      dtc_pkg::ADDR_MODE: rdata_next = timer_mode_register_reg;
      dtc_pkg::ADDR_LOW_A: rdata_next = count_low_byte_reg[0];
      dtc_pkg::ADDR_LOW_B: rdata_next = count_low_byte_reg[1];
      dtc_pkg::ADDR_HIGH_A: rdata_next = count_high_byte_reg[0];
      dtc_pkg::ADDR_HIGH_B: rdata_next = count_high_byte_reg[1];
      dtc_pkg::ADDR_CLOCK: rdata_next = {4'h0, timer_clock_register_reg};
      dtc_pkg::ADDR_IRQ_EN: rdata_next = interrupt_enable_register_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================
  // Checks
  sequence s_low_wrap(int t);
    tick[t] && mode[t] == dtc_pkg::DTC_MODE_RELOAD && count_low_byte_reg[t] == 8'hFF
      && !reg_wr;
  endsequence

  property p_reload_low;
    @(posedge core_clk) disable iff (reset)
    s_low_wrap(0) |=> count_low_byte_reg[0] == $past(count_high_byte_reg[0]);
  endproperty
  a_reload_low: assert property (p_reload_low) else $error("reload missed");

  property p_reload_high_kept;
    @(posedge core_clk) disable iff (reset)
    s_low_wrap(0) |=> $stable(count_high_byte_reg[0]);
  endproperty
  a_reload_high_kept: assert property (p_reload_high_kept) else $error("reload high moved");

  property p_flag_set;
    @(posedge core_clk) disable iff (reset)
    ovf_event[0] |=> overflow_flag[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_irq_gated;
    @(posedge core_clk) disable iff (reset)
    timer_irq[0] |-> irq_enable[0] && overflow_flag[0];
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq without enable");

  property p_stopped_hold;
    @(posedge core_clk) disable iff (reset)
    !run_bit[0] && !reg_wr |=> $stable(count_low_byte_reg[0]);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped timer moved");

  property p_gate_block;
    @(posedge core_clk) disable iff (reset)
    gate_select[0] && !gate_sync[0] && !split_active |-> !tick[0];
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("gate ignored");

  property p_prescale_period;
    @(posedge core_clk) disable iff (reset)
    prescale_tick |=> !prescale_tick [*8] ##1 !prescale_tick [*3] ##1 prescale_tick;
  endproperty
  a_prescale_period: assert property (p_prescale_period) else $error("prescale period");

  property p_toggle;
    @(posedge core_clk) disable iff (reset)
    ovf_event[0] && compare_toggle_enable[0] && !counter_select[0]
      |=> count_pin_out[0] != $past(count_pin_out[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin not toggled");

  property p_oe;
    @(posedge core_clk) disable iff (reset)
    count_pin_oe[1] == compare_toggle_enable[1];
  endproperty
  a_oe: assert property (p_oe) else $error("pin direction");
endmodule

// >>> testbench/dtc_pin_model.sv
`timescale 1ns/1ps
module dtc_pin_model (
  // Clock
  input wire logic core_clk,
  // Device side of the pins
  input wire logic [1:0] count_pin_out,
  input wire logic [1:0] count_pin_oe,
  // Levels seen by the device
  output logic [1:0] count_pin_in,
  output logic [1:0] external_gate_input
);
  logic [1:0] drive_level;
  initial begin
    drive_level = 2'h3;
    external_gate_input = 2'h0;
  end
  // ==========================================
  // Pin wire
  // The device wins while it drives; otherwise our level, idling on the pull-up
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      count_pin_in[i] = count_pin_oe[i] ? count_pin_out[i] : drive_level[i];
    end
  end
  // ==========================================
  // Stimulus tasks
  // Gap 1 gives the fastest edge rate the synchroniser must still follow
  task automatic pulses(input int t, input int n, input int gap);
    repeat (n) begin
      drive_level[t] <= 1'b0;
      repeat (gap) @(posedge core_clk);
      drive_level[t] <= 1'b1;
      repeat (gap) @(posedge core_clk);
    end
  endtask
  task automatic set_gate(input logic [1:0] lvl);
    external_gate_input <= lvl;
    @(posedge core_clk);
  endtask
endmodule

// >>> testbench/dtc_timer_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module dtc_timer_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] count_pin_in, count_pin_out, count_pin_oe, external_gate_input, timer_irq;
  logic [7:0] rd_val;
  logic prev_out;
  int error_cnt = 0;
  int n_tests = 0;
  int toggles;
  typedef struct {
    int t;
    dtc_pkg::dtc_mode_t mode;
    logic [7:0] hi, lo;
    int n;
    logic [7:0] ehi, elo;
    logic eflag;
  } dtc_row_t;
  // Counter-mode cases: timer, mode, start high/low, pulses, expected high/low/flag
  dtc_row_t rows[7] = '{
    '{0, dtc_pkg::DTC_MODE_13, 8'h00, 8'h00, 5, 8'h00, 8'h05, 1'b0},
    '{0, dtc_pkg::DTC_MODE_13, 8'hFF, 8'hFF, 1, 8'h00, 8'hE0, 1'b1},
    '{0, dtc_pkg::DTC_MODE_13, 8'h00, 8'h1F, 1, 8'h01, 8'h00, 1'b0},
    '{1, dtc_pkg::DTC_MODE_16, 8'h00, 8'hFF, 1, 8'h01, 8'h00, 1'b0},
    '{1, dtc_pkg::DTC_MODE_16, 8'hFF, 8'hFE, 2, 8'h00, 8'h00, 1'b1},
    '{0, dtc_pkg::DTC_MODE_RELOAD, 8'h80, 8'hFE, 3, 8'h80, 8'h81, 1'b1},
    '{1, dtc_pkg::DTC_MODE_RELOAD, 8'h10, 8'hFF, 1, 8'h10, 8'h10, 1'b1}
  };
  dtc_row_t r;

  always #12.5 core_clk = ~core_clk;

  dtc_timer dtc_timer_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_pin_in(count_pin_in), .count_pin_out(count_pin_out),
    .count_pin_oe(count_pin_oe), .external_gate_input(external_gate_input),
    .timer_irq(timer_irq));
  dtc_pin_model dtc_pin_model_i (.core_clk(core_clk), .count_pin_out(count_pin_out),
    .count_pin_oe(count_pin_oe), .count_pin_in(count_pin_in),
    .external_gate_input(external_gate_input));

  // ==========================================
  // Register bus tasks
  // A spare cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    @(posedge core_clk);
  endtask
  // Stop, clear flags, then load the start value before any run
  task automatic setup(input int t, input logic [7:0] mode, input logic [7:0] hi,
      input logic [7:0] lo);
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    wr(dtc_pkg::ADDR_MODE, mode);
    wr(dtc_pkg::ADDR_LOW_A + 3'(t), lo);
    wr(dtc_pkg::ADDR_HIGH_A + 3'(t), hi);
  endtask
  task automatic run(input int t);
    wr(dtc_pkg::ADDR_CONTROL, 8'(1 << (dtc_pkg::BIT_RUN_A + 2 * t)));
  endtask
  task automatic wait_irq(input int t, input int lim);
    int k = 0;
    while (timer_irq[t] !== 1'b1 && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (timer_irq[t] !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED irq wait expected 1 seen 0");
      wrap_up();
    end
  endtask
  task automatic window(input logic [7:0] clk_reg, input int cyc);
    setup(0, 8'h01, 8'h00, 8'h00);
    wr(dtc_pkg::ADDR_CLOCK, clk_reg);
    run(0);
    repeat (cyc) @(posedge core_clk);
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    rd(dtc_pkg::ADDR_LOW_A);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    `CHK("oe after reset", 2'h0, count_pin_oe);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      `CHK("reset value", 8'h00, rd_val);
    end
    wr(dtc_pkg::ADDR_IRQ_EN, 8'h0A);
    foreach (rows[i]) begin
      r = rows[i];
      setup(r.t, 8'({2'b01, r.mode}) << (4 * r.t), r.hi, r.lo);
      run(r.t);
      dtc_pin_model_i.pulses(r.t, r.n, (i % 2) ? 1 : 3);
      repeat (6) @(posedge core_clk);
      rd(dtc_pkg::ADDR_LOW_A + 3'(r.t));
      `CHK("low byte", r.elo, rd_val);
      rd(dtc_pkg::ADDR_HIGH_A + 3'(r.t));
      `CHK("high byte", r.ehi, rd_val);
      rd(dtc_pkg::ADDR_CONTROL);
      `CHK("flag", r.eflag, rd_val[dtc_pkg::BIT_FLAG_A + 2 * r.t]);
      `CHK("irq", r.eflag, timer_irq[r.t]);
    end
    // Gate held low blocks counting; stop and restart keep the count
    setup(0, 8'h0C, 8'h00, 8'h00);
    run(0);
    dtc_pin_model_i.pulses(0, 3, 2);
    repeat (6) @(posedge core_clk);
    rd(dtc_pkg::ADDR_LOW_A);
    `CHK("gated low", 8'h00, rd_val);
    dtc_pin_model_i.set_gate(2'h1);
    repeat (4) @(posedge core_clk);
    dtc_pin_model_i.pulses(0, 2, 2);
    repeat (6) @(posedge core_clk);
    rd(dtc_pkg::ADDR_LOW_A);
    `CHK("gated high", 8'h02, rd_val);
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    dtc_pin_model_i.pulses(0, 2, 2);
    repeat (6) @(posedge core_clk);
    rd(dtc_pkg::ADDR_LOW_A);
    `CHK("stopped", 8'h02, rd_val);
    run(0);
    dtc_pin_model_i.pulses(0, 1, 2);
    repeat (6) @(posedge core_clk);
    rd(dtc_pkg::ADDR_LOW_A);
    `CHK("resumed", 8'h03, rd_val);
    dtc_pin_model_i.set_gate(2'h0);
    // Clock source: undivided against divided by twelve
    window(8'h04, 40);
    `CHK("undivided", 1'b1, rd_val >= 8'h27 && rd_val <= 8'h2C);
    window(8'h00, 120);
    `CHK("divided", 1'b1, rd_val >= 8'h09 && rd_val <= 8'h0B);
    wr(dtc_pkg::ADDR_CLOCK, 8'hF0);
    rd(dtc_pkg::ADDR_CLOCK);
    `CHK("clock upper bits", 8'h00, rd_val);
    // Compare toggle on overflow every four clocks in reload mode
    setup(0, 8'h02, 8'hFC, 8'hFC);
    wr(dtc_pkg::ADDR_CLOCK, 8'h05);
    `CHK("oe forced", 2'h1, count_pin_oe);
    run(0);
    toggles = 0;
    prev_out = count_pin_out[0];
    repeat (40) begin
      @(posedge core_clk);
      #1 toggles += (count_pin_out[0] !== prev_out) ? 1 : 0;
      prev_out = count_pin_out[0];
    end
    `CHK("toggles", 1'b1, toggles >= 9 && toggles <= 11);
    `CHK("pin follows", count_pin_out[0], count_pin_in[0]);
    `CHK("toggle irq", 1'b1, timer_irq[0]);
    setup(0, 8'h00, 8'h00, 8'h00);
    wr(dtc_pkg::ADDR_CLOCK, 8'h04);
    `CHK("oe released", 2'h0, count_pin_oe);
    // Split mode: high half of timer A runs on timer B run bit and flag
    setup(0, 8'h03, 8'hF0, 8'h00);
    wr(dtc_pkg::ADDR_CONTROL, 8'h40);
    wait_irq(1, 40);
    rd(dtc_pkg::ADDR_CONTROL);
    `CHK("split control", 8'hC0, rd_val);
    rd(dtc_pkg::ADDR_LOW_A);
    `CHK("split low idle", 8'h00, rd_val);
    // Software flag set, masking and clearing
    setup(0, 8'h01, 8'h00, 8'h00);
    wr(dtc_pkg::ADDR_CONTROL, 8'h20);
    `CHK("soft flag irq", 2'h1, timer_irq);
    wr(dtc_pkg::ADDR_IRQ_EN, 8'h08);
    `CHK("masked irq", 2'h0, timer_irq);
    wr(dtc_pkg::ADDR_IRQ_EN, 8'h0A);
    `CHK("unmasked irq", 2'h1, timer_irq);
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    `CHK("cleared irq", 2'h0, timer_irq);
    wrap_up();
  end
endmodule
